// *** rtl/sar_adc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_regs.svh"
module sar_adc_ctrl (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire sar_adc_pkg::addr_t paddr,
	input wire sar_adc_pkg::data_t pwdata,
	output sar_adc_pkg::data_t prdata,
	output logic pready,
	output logic pslverr,
	// Trigger sources one to seven
	input wire logic [6:0] trigIn,
	// Analog front end
	input wire logic compBit,
	output logic anaPower,
	output logic [1:0] refSel,
	output logic [5:0] chanSel,
	output logic gainEnable,
	output logic gainHigh,
	output logic tempSel,
	output logic sampleHold,
	output sar_adc_pkg::code_t dacCode
);
	import sar_adc_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	presc_if pif ();
	data_t prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [7:0] chanReg_ff;
	logic enable_ff;
	logic autoEn_ff;
	logic doneFlag_ff;
	logic [2:0] prescSel_ff;
	logic ladj_ff;
	logic [2:0] trigSel_ff;
	code_t result_ff;
	logic lock_ff;
	logic firstPend_ff;
	conv_state_t state_ff;
	logic [4:0] cnt_ff;
	logic convFirst_ff;
	logic convAuto_ff;
	logic [7:0] convChan_ff;
	logic trialing_ff;
	logic [3:0] bitIdx_ff;
	code_t dac_ff;
	logic sampleHold_ff;
	logic sync1_ff;
	logic sync2_ff;
	logic trigPrev_ff;
	logic anaPower_ff;
	logic [1:0] refSel_ff;
	logic [5:0] chanSel_ff;
	logic gainEnable_ff;
	logic gainHigh_ff;
	logic tempSel_ff;
	logic setup;
	logic access;
	logic hit;
	logic wrCsa;
	logic swStart;
	logic trigSrc;
	logic trigEdge;
	logic autoStart;
	logic [4:0] nxt_cnt;
	logic samplePt;
	logic complete;
	logic restart;
	logic [7:0] effChan;
	logic [7:0] resLo;
	logic [7:0] resHi;
	data_t nxt_prdata;

	// Result byte of a given half in the chosen alignment
	function automatic logic [7:0] resByte(input code_t r, input logic left, input logic high);
		if (left) begin
			resByte = high ? r[9:2] : {r[1:0], 6'h00};
		end else begin
			resByte = high ? {6'h00, r[9:8]} : r[7:0];
		end
	endfunction : resByte

	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	assign pif.en = enable_ff;
	assign pif.clr = autoStart;
	assign pif.sel = prescSel_ff;

	adc_prescaler u_presc (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.p(pif.div)
	);

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	assign setup = psel && !penable;
	assign access = psel && penable && pready_ff;
	assign hit = (paddr == `OFS_CHAN) || (paddr == `OFS_CSA) || (paddr == `OFS_CSB)
		|| (paddr == `OFS_RES_LO) || (paddr == `OFS_RES_HI);
	assign wrCsa = access && pwrite && (paddr == `OFS_CSA);
	assign swStart = wrCsa && pwdata[`CSA_START] && pwdata[`CSA_ENABLE];
	assign resLo = resByte(result_ff, ladj_ff, 1'b0);
	assign resHi = resByte(result_ff, ladj_ff, 1'b1);

	// Read data mux, start bit shows activity
	always_comb begin
		nxt_prdata = 32'h0000_0000;
		unique case (paddr)
			`OFS_CHAN: nxt_prdata[7:0] = chanReg_ff;
			`OFS_CSA: nxt_prdata[7:0] = {enable_ff, state_ff != ST_IDLE, autoEn_ff,
				doneFlag_ff, 1'b0, prescSel_ff};
			`OFS_CSB: nxt_prdata[7:0] = {3'h0, ladj_ff, 1'b0, trigSel_ff};
			`OFS_RES_LO: nxt_prdata[7:0] = resLo;
			`OFS_RES_HI: nxt_prdata[7:0] = resHi;
			default: nxt_prdata = 32'h0000_0000;
		endcase
	end

	// Bus answer: one wait-free access phase
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_ff <= 32'h0000_0000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= setup;
			pslverr_ff <= setup && !hit;
			if (setup && !pwrite) begin
				prdata_ff <= nxt_prdata;
			end
		end
	end

	// Software-written configuration
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			chanReg_ff <= `CHAN_RST;
			enable_ff <= 1'b0;
			autoEn_ff <= 1'b0;
			prescSel_ff <= `PRESC_RST;
			ladj_ff <= 1'b0;
			trigSel_ff <= `TRIG_RST;
		end else if (access && pwrite) begin
			if (paddr == `OFS_CHAN) begin
				chanReg_ff <= pwdata[7:0];
			end
			if (paddr == `OFS_CSA) begin
				enable_ff <= pwdata[`CSA_ENABLE];
				autoEn_ff <= pwdata[`CSA_AUTO];
				prescSel_ff <= pwdata[2:0];
			end
			if (paddr == `OFS_CSB) begin
				ladj_ff <= pwdata[`CSB_LADJ];
				trigSel_ff <= pwdata[2:0];
			end
		end
	end

	// Read lock: result_low read blocks updates until result_high read
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_ff <= 1'b0;
		end else if (setup && !pwrite && paddr == `OFS_RES_LO) begin
			lock_ff <= 1'b1;
		end else if (setup && !pwrite && paddr == `OFS_RES_HI) begin
			lock_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Trigger path
	// ----------------------------------------
	assign trigSrc = (trigSel_ff == `TRIG_FREE_RUN) ? doneFlag_ff
		: trigIn[trigSel_ff - 3'h1];
	assign trigEdge = sync2_ff && !trigPrev_ff;
	assign autoStart = enable_ff && autoEn_ff && trigEdge && state_ff == ST_IDLE;

	// Three-cycle synchroniser and edge detector
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			trigPrev_ff <= 1'b0;
		end else begin
			sync1_ff <= trigSrc;
			sync2_ff <= sync1_ff;
			trigPrev_ff <= sync2_ff;
		end
	end

	// Done flag: set wins over write-one-clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			doneFlag_ff <= 1'b0;
		end else if (complete) begin
			doneFlag_ff <= 1'b1;
		end else if (wrCsa && pwdata[`CSA_DONE]) begin
			doneFlag_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Conversion sequencer
	// ----------------------------------------
	assign nxt_cnt = 5'(cnt_ff + 5'd1);
	assign samplePt = state_ff == ST_CONV && (convAuto_ff
		? (pif.rise && nxt_cnt == `AUTO_SAMPLE)
		: (pif.fall && cnt_ff == (convFirst_ff ? `FIRST_SAMPLE : `NORM_SAMPLE)));
	assign complete = state_ff == ST_CONV && enable_ff && (convAuto_ff
		? (pif.fall && cnt_ff == `AUTO_END)
		: (pif.rise && nxt_cnt == (convFirst_ff ? `FIRST_END : `NORM_END)));
	assign restart = autoEn_ff && trigSel_ff == `TRIG_FREE_RUN;
	assign effChan = (state_ff == ST_CONV) ? convChan_ff : chanReg_ff;

	// State, cycle count and per-conversion attributes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 5'd0;
			convFirst_ff <= 1'b0;
			convAuto_ff <= 1'b0;
			convChan_ff <= `CHAN_RST;
		end else if (!enable_ff && !swStart) begin // Enable and start may share one write
			state_ff <= ST_IDLE;
			cnt_ff <= 5'd0;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					if (swStart) begin
						state_ff <= ST_ARMED;
					end else if (autoStart) begin
						state_ff <= ST_CONV;
						cnt_ff <= 5'd0;
						convAuto_ff <= 1'b1;
						convFirst_ff <= 1'b0;
						convChan_ff <= chanReg_ff;
					end
				end
				ST_ARMED: begin
					if (pif.rise) begin
						state_ff <= ST_CONV;
						cnt_ff <= 5'd0;
						convAuto_ff <= 1'b0;
						convFirst_ff <= firstPend_ff;
						convChan_ff <= chanReg_ff;
					end
				end
				ST_CONV: begin
					if (complete && restart) begin
						cnt_ff <= 5'd0;
						convAuto_ff <= 1'b0;
						convFirst_ff <= 1'b0;
						convChan_ff <= chanReg_ff;
					end else if (complete) begin
						state_ff <= ST_IDLE;
					end else if (pif.rise) begin
						cnt_ff <= nxt_cnt;
					end
				end
			endcase
		end
	end

	// First conversion after enable runs long if software-started; an earlier auto start cancels it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			firstPend_ff <= 1'b1;
		end else if (!enable_ff) begin
			firstPend_ff <= 1'b1;
		end else if (state_ff == ST_ARMED && pif.rise) begin
			firstPend_ff <= 1'b0;
		end else if (autoStart) begin
			firstPend_ff <= 1'b0;
		end
	end

	// Successive approximation, one trial per rising edge
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			trialing_ff <= 1'b0;
			bitIdx_ff <= 4'd0;
			dac_ff <= 10'h000;
			sampleHold_ff <= 1'b0;
		end else begin
			sampleHold_ff <= samplePt && enable_ff;
			if (!enable_ff) begin
				trialing_ff <= 1'b0;
			end else if (samplePt) begin
				trialing_ff <= 1'b1;
				bitIdx_ff <= 4'd9;
				dac_ff <= 10'h200;
			end else if (trialing_ff && pif.rise) begin
				dac_ff[bitIdx_ff] <= compBit;
				if (bitIdx_ff != 4'd0) begin
					dac_ff[bitIdx_ff - 4'd1] <= 1'b1;
					bitIdx_ff <= bitIdx_ff - 4'd1;
				end else begin
					trialing_ff <= 1'b0;
				end
			end
		end
	end

	// Result register, frozen while the read lock holds
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			result_ff <= 10'h000;
		end else if (complete && !lock_ff && !(setup && !pwrite && paddr == `OFS_RES_LO)) begin
			result_ff <= dac_ff;
		end
	end

	// Analog steering, all off while disabled
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			anaPower_ff <= 1'b0;
			refSel_ff <= 2'h0;
			chanSel_ff <= 6'h00;
			gainEnable_ff <= 1'b0;
			gainHigh_ff <= 1'b0;
			tempSel_ff <= 1'b0;
		end else begin
			anaPower_ff <= enable_ff;
			refSel_ff <= enable_ff ? effChan[`CHAN_REF_LSB +: 2] : 2'h0;
			chanSel_ff <= enable_ff ? effChan[5:0] : 6'h00;
			tempSel_ff <= enable_ff && effChan[5:0] == `TEMP_SENSOR_CODE;
			gainEnable_ff <= enable_ff && effChan[5:0] > `SINGLE_LAST_CODE
				&& effChan[5:0] != `TEMP_SENSOR_CODE;
			gainHigh_ff <= enable_ff && effChan[5:0] > `SINGLE_LAST_CODE
				&& effChan[5:0] != `TEMP_SENSOR_CODE && effChan[0];
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign anaPower = anaPower_ff;
	assign refSel = refSel_ff;
	assign chanSel = chanSel_ff;
	assign gainEnable = gainEnable_ff;
	assign gainHigh = gainHigh_ff;
	assign tempSel = tempSel_ff;
	assign sampleHold = sampleHold_ff;
	assign dacCode = dac_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_armed_edge;
		state_ff == ST_ARMED && enable_ff ##0 pif.rise;
	endsequence

	sequence s_single_done;
		complete ##0 !restart;
	endsequence

	a_start_on_edge: assert property (s_armed_edge |=> state_ff == ST_CONV && cnt_ff == 5'd0)
		else $error("software start not taken at converter edge");
	a_done_flag_set: assert property (complete |=> doneFlag_ff)
		else $error("done flag not set at completion");
	a_lock_holds: assert property (complete && lock_ff |=> $stable(result_ff))
		else $error("result changed while read lock held");
	a_single_clears: assert property (s_single_done |=> state_ff == ST_IDLE)
		else $error("start bit not cleared after single conversion");
	a_free_restart: assert property (complete && restart |=> state_ff == ST_CONV && cnt_ff == 5'd0)
		else $error("free-running conversion did not restart");
	a_no_power_off: assert property (!enable_ff |=> !anaPower && chanSel == 6'h00)
		else $error("analog path active while disabled");
	a_sample_normal: assert property (samplePt && !convAuto_ff && !convFirst_ff |-> pif.fall && cnt_ff == 5'd1)
		else $error("normal sample not at 1.5 cycles");
	a_sample_auto: assert property (samplePt && convAuto_ff |-> pif.rise && cnt_ff == 5'd1)
		else $error("auto sample not at 2 cycles");
	a_channel_locked: assert property (state_ff == ST_CONV && $past(state_ff) == ST_CONV && !$past(complete) |-> $stable(convChan_ff))
		else $error("channel changed during conversion");
	a_trig_ignored: assert property (state_ff == ST_CONV && trigEdge && !complete |=> !pif.clr)
		else $error("trigger edge acted during conversion");

endmodule : sar_adc_ctrl
`default_nettype wire

// *** rtl/sar_adc_regs.svh ***
// Functional notes
// - Produce a 10-bit code by successive approximation, ground to reference.
// - reference_select picks supply, external_reference_pin or internal 1.1V reference.
// - Single-ended inputs bypass the gain stage; differential pairs use 1x or 20x.
// - Code 100010 in channel_gain_select routes the temperature sensor.
// - Selections act only while converter_enable is set; otherwise no power.
// - Result is right-aligned by default, left-aligned when left_adjust is set.
// - Reading result_low blocks result updates until result_high is read.
// - conversion_done_flag still sets when a finished result is discarded.
// - Writing start_conversion starts one conversion; hardware clears it at the end.
// - A channel change during conversion applies only after that conversion.
// - With auto trigger on, a source rising edge resets prescaler and starts.
// - A trigger still high at completion or edges during conversion start nothing.
// - Trigger flags set regardless of masking; software clears them for a new edge.
// - Done flag as trigger converts back to back; software starts the first.
// - start_conversion reads one while busy; writing it starts even with auto trigger.
// - Prescaler runs while converter_enable is set and is held reset while clear.
// - A software start begins at the next rising converter clock edge.
// - Normal conversion lasts 13 converter cycles, the first after enable 25.
// - Sample-and-hold at 1.5 cycles normally, 14.5 cycles on the first conversion.
// - Completion writes result and sets the done flag; single mode clears start.
// - Auto-triggered: sample at 2 cycles, done at 13.5, three-cycle trigger sync.
// - Free-running restarts right after completion with start_conversion kept set.
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CHAN 8'h00
`define OFS_CSA 8'h04
`define OFS_CSB 8'h08
`define OFS_RES_LO 8'h0c
`define OFS_RES_HI 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CSA_ENABLE 7
`define CSA_START 6
`define CSA_AUTO 5
`define CSA_DONE 4
`define CSB_LADJ 4
`define CHAN_REF_LSB 6

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define CHAN_RST 8'h00
`define PRESC_RST 3'h0
`define TRIG_RST 3'h0
`define TRIG_FREE_RUN 3'h0
`define TEMP_SENSOR_CODE 6'h22
`define SINGLE_LAST_CODE 6'h07

// ----------------------------------------
// Timing counts in converter clock cycles
// ----------------------------------------
`define NORM_END 5'd13
`define FIRST_END 5'd25
`define NORM_SAMPLE 5'd1
`define FIRST_SAMPLE 5'd14
`define AUTO_SAMPLE 5'd2
`define AUTO_END 5'd13

`endif

// *** rtl/sar_adc_pkg.sv ***
package sar_adc_pkg;
	typedef logic [7:0] addr_t;
	typedef logic [31:0] data_t;
	typedef logic [9:0] code_t;
	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CONV} conv_state_t;
endpackage : sar_adc_pkg

// *** rtl/presc_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface presc_if;
	logic en;
	logic clr;
	logic [2:0] sel;
	logic rise;
	logic fall;
	modport ctrl (output en, output clr, output sel, input rise, input fall);
	modport div (input en, input clr, input sel, output rise, output fall);
endinterface : presc_if
`default_nettype wire

// *** rtl/adc_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_regs.svh"
module adc_prescaler (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Control and converter clock edges
	presc_if.div p
);
	import sar_adc_pkg::*;

	logic [6:0] cnt_ff;
	logic rise_ff;
	logic fall_ff;
	logic [6:0] last;

	// Last count of a 2^n period, n at least one
	function automatic logic [6:0] lastCount(input logic [2:0] s);
		logic [2:0] e;
		e = (s == 3'h0) ? 3'h1 : s;
		lastCount = 7'((8'h01 << e) - 8'h01);
	endfunction : lastCount

	assign last = lastCount(p.sel);
	assign p.rise = rise_ff;
	assign p.fall = fall_ff;

	// Divider, held in reset while disabled or on trigger
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 7'h00;
			rise_ff <= 1'b0;
			fall_ff <= 1'b0;
		end else if (!p.en || p.clr) begin
			cnt_ff <= 7'h00;
			rise_ff <= 1'b0;
			fall_ff <= 1'b0;
		end else begin
			cnt_ff <= (cnt_ff == last) ? 7'h00 : 7'(cnt_ff + 7'h01);
			rise_ff <= (cnt_ff == last);
			fall_ff <= (cnt_ff == (last >> 1));
		end
	end

	a_held_disabled: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!p.en |=> !p.rise && !p.fall)
		else $error("prescaler edge while disabled");

endmodule : adc_prescaler
`default_nettype wire

// *** test/adc_front_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_front_model (
	// Clock
	input wire logic sys_clk,
	// Selection in effect
	input wire logic anaPower,
	input wire logic [1:0] refSel,
	input wire logic [5:0] chanSel,
	input wire logic gainHigh,
	input wire logic tempSel,
	// Converter core
	input wire sar_adc_pkg::code_t dacCode,
	output logic compBit
);
	import sar_adc_pkg::*;
	code_t level;
	logic junk = 1'b0;
	// Input level encodes the route, so every result shows what was sampled
	assign level = {chanSel, refSel, gainHigh, tempSel};
	// Unpowered comparator output wanders every cycle
	always @(posedge sys_clk) junk <= ~junk;
	// Keep the trial bit while the trial is not above the level
	assign compBit = anaPower ? (dacCode <= level) : junk;
endmodule : adc_front_model
`default_nettype wire

// *** test/sar_adc_conversion_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_regs.svh"
module sar_adc_conversion_control_test;
	import sar_adc_pkg::*;
	typedef struct {logic [7:0] ch; logic ladj;} row_t;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	addr_t paddr = 8'h00;
	data_t pwdata = 32'h0;
	data_t prdata, rd;
	logic pready, pslverr, err, compBit, anaPower, gainEnable, gainHigh, tempSel, sampleHold;
	logic [6:0] trigIn = 7'h00;
	logic [1:0] refSel;
	logic [5:0] chanSel;
	code_t dacCode, e;
	int errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	int shCount = 0;
	int shAt = 0;
	int shGap = 0;
	int startAt, t0, n0;
	row_t rows[6] = '{'{8'h05, 1'b0}, '{8'h43, 1'b1}, '{8'h88, 1'b0}, '{8'h09, 1'b1},
		'{8'h22, 1'b0}, '{8'h62, 1'b1}};

	sar_adc_ctrl DUT (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .trigIn, .compBit, .anaPower, .refSel, .chanSel, .gainEnable,
		.gainHigh, .tempSel, .sampleHold, .dacCode);
	adc_front_model front (.sys_clk, .anaPower, .refSel, .chanSel, .gainHigh, .tempSel,
		.dacCode, .compBit);

	// Clock
	initial forever #2.5 sys_clk = ~sys_clk;

	// Cycle count, sample pulse log and hang guard
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (sampleHold === 1'b1) begin
			shCount <= shCount + 1;
			shAt <= cyc;
			shGap <= cyc - shAt;
		end
		if (cyc > 20000) begin
			errors = errors + 1;
			end_sim();
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(data_t seen, data_t exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer, held until pready is sampled high
	task automatic apb(logic wr, addr_t a, data_t d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) errors++;
		rd = prdata;
		err = pslverr;
		startAt = cyc;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Poll until the start bit drops
	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			apb(1'b0, `OFS_CSA, 32'h0);
			n++;
		end while (rd[6] !== 1'b0 && n < 100);
	endtask : wait_idle

	function automatic code_t exp_code(logic [7:0] ch);
		logic t;
		t = ch[5:0] == 6'h22;
		return {ch[5:0], ch[7:6], ch[5:0] > 6'h07 && !t && ch[0], t};
	endfunction : exp_code

	function automatic data_t exp_lo(code_t c, logic l);
		return l ? {24'h0, c[1:0], 6'h00} : {24'h0, c[7:0]};
	endfunction : exp_lo

	function automatic data_t exp_hi(code_t c, logic l);
		return l ? {24'h0, c[9:2]} : {22'h0, c[9:8]};
	endfunction : exp_hi

	task automatic end_sim;
		$display("Checks %0d, errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		// Single conversions over the row table, first one after enable
		foreach (rows[i]) begin
			e = exp_code(rows[i].ch);
			apb(1'b1, `OFS_CHAN, {24'h0, rows[i].ch});
			apb(1'b1, `OFS_CSB, {27'h0, rows[i].ladj, 4'h0});
			apb(1'b1, `OFS_CSA, 32'hc1);
			t0 = (i == 0) ? startAt + 29 : startAt + 3;
			wait_idle();
			check(data_t'(shAt >= t0 && shAt <= t0 + 4), 32'h1);
			check(rd, 32'h91);
			check(data_t'({gainEnable, tempSel, refSel, chanSel}),
				data_t'({e[1] | (rows[i].ch[5:0] > 6'h07 && !e[0]), e[0], rows[i].ch}));
			apb(1'b0, `OFS_RES_LO, 32'h0);
			check(rd, exp_lo(e, rows[i].ladj));
			apb(1'b0, `OFS_RES_HI, 32'h0);
			check(rd, exp_hi(e, rows[i].ladj));
		end
		// Disabled: nothing routed, start refused
		apb(1'b1, `OFS_CSA, 32'h00);
		apb(1'b1, `OFS_CHAN, 32'h45);
		apb(1'b1, `OFS_CSA, 32'h40);
		apb(1'b0, `OFS_CSA, 32'h0);
		check(rd, 32'h10);
		check(data_t'({anaPower, refSel, chanSel}), 32'h0);
		// Channel change mid-conversion, then a result lost under the read lock
		e = exp_code(8'h03);
		apb(1'b1, `OFS_CSB, 32'h0);
		apb(1'b1, `OFS_CHAN, 32'h03);
		apb(1'b1, `OFS_CSA, 32'hc1);
		apb(1'b1, `OFS_CHAN, 32'h06);
		wait_idle();
		apb(1'b0, `OFS_RES_LO, 32'h0);
		check(rd, exp_lo(e, 1'b0));
		apb(1'b1, `OFS_CSA, 32'hd1);
		wait_idle();
		check(rd, 32'h91);
		apb(1'b0, `OFS_RES_HI, 32'h0);
		check(rd, exp_hi(e, 1'b0));
		apb(1'b0, `OFS_RES_LO, 32'h0);
		check(rd, exp_lo(e, 1'b0));
		// Each trigger source; a second edge and a held level start nothing more
		apb(1'b1, `OFS_CSA, 32'hb1);
		for (int s = 1; s < 8; s++) begin
			apb(1'b1, `OFS_CSB, data_t'(s));
			n0 = shCount;
			trigIn[s - 1] <= 1'b1;
			repeat (4) @(posedge sys_clk);
			apb(1'b0, `OFS_CSA, 32'h0);
			check(data_t'(rd[6]), 32'h1);
			trigIn[s - 1] <= 1'b0;
			repeat (2) @(posedge sys_clk);
			trigIn[s - 1] <= 1'b1;
			wait_idle();
			repeat (60) @(posedge sys_clk);
			check(data_t'(shCount - n0), 32'h1);
			trigIn <= 7'h00;
			apb(1'b1, `OFS_CSA, 32'hb1);
		end
		// Free running on the done flag, flag never cleared
		apb(1'b1, `OFS_CSB, 32'h0);
		apb(1'b1, `OFS_CSA, 32'he1);
		n0 = shCount;
		repeat (200) @(posedge sys_clk);
		apb(1'b0, `OFS_CSA, 32'h0);
		check(data_t'(rd[6]), 32'h1);
		check(data_t'(shCount - n0 >= 6), 32'h1);
		check(data_t'(shGap), 32'd26);
		apb(1'b1, `OFS_CSA, 32'he3);
		repeat (350) @(posedge sys_clk);
		check(data_t'(shGap), 32'd104);
		apb(1'b1, `OFS_CSA, 32'h00);
		n0 = shCount;
		repeat (100) @(posedge sys_clk);
		check(data_t'(shCount - n0), 32'h0);
		check(data_t'(anaPower), 32'h0);
		// Second reset, then reset values and an unmapped address
		rst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 24; a += 4) begin
			apb(1'b0, addr_t'(a), 32'h0);
			check(rd, 32'h0);
			check(data_t'(err), data_t'(a == 20));
		end
		end_sim();
	end
endmodule : sar_adc_conversion_control_test
`default_nettype wire
